/* File: shared/perf_event_select_regs.vh */
// Event codes, unit masks and widths for the performance event selector
`ifndef PERF_EVENT_SELECT_REGS_VH
`define PERF_EVENT_SELECT_REGS_VH

`define EVT_LOAD_XLATE_MISS   8'hCB
`define UM_LOAD_XLATE_MISS    8'h04
`define EVT_VECTOR_ASSIST     8'hCD
`define UM_VECTOR_ASSIST      8'h00
`define EVT_VECTOR_RETIRE     8'hCE
`define UM_VECTOR_RETIRE      8'h00
`define EVT_SAT_VECTOR_RETIRE 8'hCF
`define UM_SAT_VECTOR_RETIRE  8'h00
`define EVT_BRANCH_DECODE     8'hE0
`define UM_BRANCH_DECODE      8'h01
`define EVT_FALSE_BRANCH      8'hE4
`define UM_FALSE_BRANCH       8'h01
`define EVT_FRONT_REDIRECT    8'hE6
`define UM_FRONT_REDIRECT     8'h01

`define EVT_WIDTH             8
`define CNT_WIDTH_DEFAULT     48
`define CNT_RESET             48'h000000000000

`endif

/* File: hw/perf_event_select.v */
// Event selection and counting for one performance counter
`timescale 1ns/1ps
`include "perf_event_select_regs.vh"

module perf_event_select #(
   parameter CNT_WIDTH = `CNT_WIDTH_DEFAULT
) (
   input  wire                   i_clk,
   input  wire                   i_srst,
   input  wire [`EVT_WIDTH-1:0]  i_event_num,
   input  wire [`EVT_WIDTH-1:0]  i_unit_mask,
   input  wire                   i_count_clear,
   input  wire                   i_load_retire,
   input  wire                   i_load_xlate_miss,
   input  wire                   i_load_fault,
   input  wire                   i_mm_clear_assist,
   input  wire                   i_vec_denormal_in,
   input  wire                   i_vec_underflow_out,
   input  wire                   i_denormals_as_zero_flag,
   input  wire                   i_flush_underflow_zero_flag,
   input  wire                   i_vec_retire,
   input  wire                   i_vec_saturating,
   input  wire                   i_branch_decode,
   input  wire                   i_false_branch_detect,
   input  wire                   i_front_end_redirect,
   output reg                    o_front_end_clear,
   output reg                    o_target_buffer_flush,
   output reg                    o_vector_assist,
   output reg                    o_count_inc,
   output reg  [CNT_WIDTH-1:0]   o_count
);

   // Gated event pulses, one per table entry
   wire                 hit_load_miss;
   wire                 hit_assist;
   wire                 hit_vec_ret;
   wire                 hit_sat_ret;
   wire                 hit_br_dec;
   wire                 hit_false_br;
   wire                 hit_redirect;

   reg                  retired_load_translation_miss;
   reg                  vector_assist_count;
   reg                  denormal_assist;
   reg                  underflow_assist;
   reg                  saturating_vector_retire;
   reg                  front_end_redirect_any;
   reg                  count_inc_nxt;
   reg  [CNT_WIDTH-1:0] count_nxt;

   // Event conditioning ahead of the selector
   always @* begin
      // A faulting load never reaches the count
      retired_load_translation_miss = i_load_retire && i_load_xlate_miss && !i_load_fault;
      // Each flag masks only its own assist cause; the clear assist is never masked
      denormal_assist               = i_vec_denormal_in && !i_denormals_as_zero_flag;
      underflow_assist              = i_vec_underflow_out && !i_flush_underflow_zero_flag;
      vector_assist_count           = i_mm_clear_assist || denormal_assist || underflow_assist;
      // Saturating retire is a subset of vector retire
      saturating_vector_retire      = i_vec_retire && i_vec_saturating;
      // A false branch is itself a redirect, so it counts here too
      front_end_redirect_any        = i_front_end_redirect || i_false_branch_detect;
   end

   // One matcher per table entry; load, assist, saturating and redirect pulses arrive already qualified
   event_match #(
      .EVT_W    (`EVT_WIDTH),
      .EVT_CODE (`EVT_LOAD_XLATE_MISS),
      .UM_CODE  (`UM_LOAD_XLATE_MISS)
   ) event_match_load_i (
      .i_event_num (i_event_num),
      .i_unit_mask (i_unit_mask),
      .i_pulse     (retired_load_translation_miss),
      .o_hit       (hit_load_miss)
   );

   event_match #(
      .EVT_W    (`EVT_WIDTH),
      .EVT_CODE (`EVT_VECTOR_ASSIST),
      .UM_CODE  (`UM_VECTOR_ASSIST)
   ) event_match_assist_i (
      .i_event_num (i_event_num),
      .i_unit_mask (i_unit_mask),
      .i_pulse     (vector_assist_count),
      .o_hit       (hit_assist)
   );

   event_match #(
      .EVT_W    (`EVT_WIDTH),
      .EVT_CODE (`EVT_VECTOR_RETIRE),
      .UM_CODE  (`UM_VECTOR_RETIRE)
   ) event_match_vec_i (
      .i_event_num (i_event_num),
      .i_unit_mask (i_unit_mask),
      .i_pulse     (i_vec_retire),
      .o_hit       (hit_vec_ret)
   );

   event_match #(
      .EVT_W    (`EVT_WIDTH),
      .EVT_CODE (`EVT_SAT_VECTOR_RETIRE),
      .UM_CODE  (`UM_SAT_VECTOR_RETIRE)
   ) event_match_sat_i (
      .i_event_num (i_event_num),
      .i_unit_mask (i_unit_mask),
      .i_pulse     (saturating_vector_retire),
      .o_hit       (hit_sat_ret)
   );

   event_match #(
      .EVT_W    (`EVT_WIDTH),
      .EVT_CODE (`EVT_BRANCH_DECODE),
      .UM_CODE  (`UM_BRANCH_DECODE)
   ) event_match_branch_i (
      .i_event_num (i_event_num),
      .i_unit_mask (i_unit_mask),
      .i_pulse     (i_branch_decode),
      .o_hit       (hit_br_dec)
   );

   event_match #(
      .EVT_W    (`EVT_WIDTH),
      .EVT_CODE (`EVT_FALSE_BRANCH),
      .UM_CODE  (`UM_FALSE_BRANCH)
   ) event_match_false_i (
      .i_event_num (i_event_num),
      .i_unit_mask (i_unit_mask),
      .i_pulse     (i_false_branch_detect),
      .o_hit       (hit_false_br)
   );

   event_match #(
      .EVT_W    (`EVT_WIDTH),
      .EVT_CODE (`EVT_FRONT_REDIRECT),
      .UM_CODE  (`UM_FRONT_REDIRECT)
   ) event_match_redirect_i (
      .i_event_num (i_event_num),
      .i_unit_mask (i_unit_mask),
      .i_pulse     (front_end_redirect_any),
      .o_hit       (hit_redirect)
   );

   // Only one selection can match, so the OR never merges two counts
   always @* begin
      count_inc_nxt = hit_load_miss
                    | hit_assist
                    | hit_vec_ret
                    | hit_sat_ret
                    | hit_br_dec
                    | hit_false_br
                    | hit_redirect;
      // Clear wins over an increment in the same cycle; counter wraps silently
      if (i_count_clear)
         count_nxt = {CNT_WIDTH{1'b0}};
      else if (count_inc_nxt)
         count_nxt = o_count + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
      else
         count_nxt = o_count;
   end

   // Registered outputs trade one cycle of latency for clean timing
   always @(posedge i_clk) begin
      if (i_srst) begin
         o_front_end_clear     <= 1'b0;
         o_target_buffer_flush <= 1'b0;
         o_vector_assist       <= 1'b0;
         o_count_inc           <= 1'b0;
         o_count               <= {CNT_WIDTH{1'b0}};
      end else begin
         o_front_end_clear     <= front_end_redirect_any;
         o_target_buffer_flush <= i_false_branch_detect;
         o_vector_assist       <= vector_assist_count;
         o_count_inc           <= count_inc_nxt;
         o_count               <= count_nxt;
      end
   end

endmodule

// Matches one event number and unit mask pair and gates its pulse
// Unit mask bits are compared whole; no per-bit qualification is supported
module event_match #(
   parameter EVT_W    = 8,
   parameter EVT_CODE = 8'h00,
   parameter UM_CODE  = 8'h00
) (
   input  wire [EVT_W-1:0] i_event_num,
   input  wire [EVT_W-1:0] i_unit_mask,
   input  wire             i_pulse,
   output wire             o_hit
);

   wire                    evt_match;
   wire                    um_match;
   wire                    sel_match;

   // Both fields must match; a partial match would leak a neighbouring event
   assign evt_match = (i_event_num == EVT_CODE[EVT_W-1:0]);
   assign um_match  = (i_unit_mask == UM_CODE[EVT_W-1:0]);
   assign sel_match = evt_match && um_match;
   assign o_hit     = sel_match && i_pulse;

endmodule

/* File: verif/event_source_model.sv */
// Pipeline event source: replays each request one cycle later
`timescale 1ns/1ps
module event_source_model (
   input  wire logic        i_clk,
   input  wire logic [12:0] i_req,
   output logic      [12:0] o_pulse = 13'h0000
);
   always @(posedge i_clk) o_pulse <= i_req;
endmodule

/* File: verif/perf_event_select_checker.sv */
// Port assertions for the event selector
`timescale 1ns/1ps
module perf_event_select_checker #(parameter CNT_WIDTH = 48) (input logic i_clk, i_srst, i_count_clear, i_load_fault,
   i_false_branch_detect, i_front_end_redirect, o_front_end_clear, o_target_buffer_flush, o_count_inc,
   input logic [7:0] i_event_num, i_unit_mask, input logic [CNT_WIDTH-1:0] o_count);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   a_fault_skip: assert property (i_event_num==8'hCB && i_load_fault |=> !o_count_inc) else $error("fault");
   a_flush_now: assert property (i_false_branch_detect |=> o_target_buffer_flush) else $error("no flush");
   a_bogus_clear: assert property (i_false_branch_detect |=> o_front_end_clear) else $error("no clear");
   a_flush_src: assert property (o_target_buffer_flush |-> $past(i_false_branch_detect)) else $error("stray");
   a_fe_clear: assert property (i_front_end_redirect |=> o_front_end_clear) else $error("no redirect");
   a_no_match: assert property (i_event_num == 8'h00 |=> !o_count_inc) else $error("unmatched");
   a_count_step: assert property (o_count_inc && !$past(i_count_clear) |-> o_count == $past(o_count) + 1'b1)
      else $error("bad step");
   a_count_hold: assert property (!o_count_inc && !$past(i_count_clear | i_srst) |-> $stable(o_count))
      else $error("count moved");
   c_inc: cover property (o_count_inc);
   c_flush: cover property (o_target_buffer_flush);
   c_redirect: cover property (o_front_end_clear && !o_target_buffer_flush);
endmodule
bind perf_event_select perf_event_select_checker #(.CNT_WIDTH(CNT_WIDTH)) perf_event_select_checker_i (.*);

/* File: verif/perf_event_select_tb.sv */
// Self-checking bench for the event selector
`timescale 1ns/1ps
module perf_event_select_tb;
   logic clk = 0, srst = 1, clr = 0;
   logic [28:0] cmd = 29'h00000000;
   logic [12:0] p;
   logic fe_clr, flush, assist, inc;
   logic [47:0] cnt;
   int bad_count = 0, checks_done = 0, cyc = 0;
   always #25 clk = ~clk;
   event_source_model event_source_model_i (.i_clk(clk), .i_req(cmd[12:0]), .o_pulse(p));
   perf_event_select perf_event_select_i (.i_clk(clk), .i_srst(srst), .i_event_num(cmd[28:21]),
      .i_unit_mask(cmd[20:13]), .i_count_clear(clr), .i_load_retire(p[12]), .i_load_xlate_miss(p[11]),
      .i_load_fault(p[10]), .i_mm_clear_assist(p[9]), .i_vec_denormal_in(p[8]), .i_vec_underflow_out(p[7]),
      .i_denormals_as_zero_flag(p[6]), .i_flush_underflow_zero_flag(p[5]), .i_vec_retire(p[4]),
      .i_vec_saturating(p[3]), .i_branch_decode(p[2]), .i_false_branch_detect(p[1]),
      .i_front_end_redirect(p[0]), .o_front_end_clear(fe_clr), .o_target_buffer_flush(flush),
      .o_vector_assist(assist), .o_count_inc(inc), .o_count(cnt));
   task chk(input logic [47:0] got, exp);
      checks_done++;
      bad_count += (got !== exp);
      if (got !== exp) $display("[ERR] %0t count %0h, expected %0h", $time, got, exp);
   endtask
   // Event lands one cycle after the command, through the model, the count one cycle later still
   task drive(input logic [28:0] c);
      @(posedge clk) cmd <= c;
      @(posedge clk) cmd[12:0] <= 13'h0000;
      repeat (2) @(negedge clk);
   endtask
   task load_miss_test;
      drive({8'hCB, 8'h04, 13'h1800});
      chk(cnt, 48'h1);
      chk(inc, 48'h1);
      drive({8'hCB, 8'h04, 13'h1C00});
      chk(cnt, 48'h1);
      chk(inc, 48'h0);
      drive({8'hCB, 8'h04, 13'h0800});
      chk(cnt, 48'h1);
   endtask
   task assist_test;
      drive({8'hCD, 8'h00, 13'h0100});
      chk(cnt, 48'h2);
      chk(assist, 48'h1);
      drive({8'hCD, 8'h00, 13'h0140});
      chk(cnt, 48'h2);
      chk(assist, 48'h0);
      drive({8'hCD, 8'h00, 13'h0080});
      chk(cnt, 48'h3);
      drive({8'hCD, 8'h00, 13'h00A0});
      chk(cnt, 48'h3);
      drive({8'hCD, 8'h00, 13'h0200});
      chk(cnt, 48'h4);
      chk(assist, 48'h1);
      drive({8'hCD, 8'h01, 13'h0200});
      chk(cnt, 48'h4);
   endtask
   task vector_test;
      drive({8'hCE, 8'h00, 13'h0010});
      chk(cnt, 48'h5);
      drive({8'hCF, 8'h00, 13'h0010});
      chk(cnt, 48'h5);
      drive({8'hCF, 8'h00, 13'h0018});
      chk(cnt, 48'h6);
      drive({8'hCE, 8'h01, 13'h0010});
      chk(cnt, 48'h6);
   endtask
   task branch_test;
      drive({8'hE0, 8'h01, 13'h0004});
      chk(cnt, 48'h7);
      drive({8'hE4, 8'h01, 13'h0002});
      chk(cnt, 48'h8);
      chk(fe_clr, 48'h1);
      chk(flush, 48'h1);
      drive({8'hE6, 8'h01, 13'h0001});
      chk(cnt, 48'h9);
      chk(fe_clr, 48'h1);
      chk(flush, 48'h0);
      drive({8'hE4, 8'h01, 13'h0001});
      chk(cnt, 48'h9);
      drive({8'h00, 8'h00, 13'h1FFF});
      chk(cnt, 48'h9);
   endtask
   task clear_test;
      @(posedge clk) clr <= 1'b1;
      @(posedge clk) clr <= 1'b0;
      @(negedge clk);
      chk(cnt, 48'h0);
      @(posedge clk) cmd <= {8'hCE, 8'h00, 13'h0010};
      @(posedge clk) begin
         cmd[12:0] <= 13'h0000;
         clr <= 1'b1;
      end
      @(posedge clk) clr <= 1'b0;
      @(negedge clk);
      chk(cnt, 48'h0);
      chk(inc, 48'h1);
   endtask
   task reset_mid_test;
      drive({8'hCE, 8'h00, 13'h0010});
      chk(cnt, 48'h1);
      @(posedge clk) srst <= 1'b1;
      @(posedge clk) srst <= 1'b0;
      @(negedge clk);
      chk(cnt, 48'h0);
      drive({8'hCE, 8'h00, 13'h0010});
      chk(cnt, 48'h1);
   endtask
   task report_and_stop(input int extra);
      bad_count += extra;
      if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk) if (++cyc == 1000) report_and_stop(1);
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      load_miss_test();
      assist_test();
      vector_test();
      branch_test();
      clear_test();
      reset_mid_test();
      report_and_stop(0);
   end
endmodule
